// ### core/idc_cfg_if.sv
/*
 Carrier of raw configuration and cleaned capability fields between the
 register file, the consistency stage and the word assembler.
 Assumes all three sit on one clock.
*/
`timescale 1ns/1ps
interface idc_cfg_if;
  logic [7:0] mult_max, pio_mode, mult_cnt, s_pio_mode, s_pio_adv;
  logic stby_std, iordy_sup, iordy_dis, min_stby, geom_val, udma_val, ext_val;
  logic mult_val, s_iordy, s_ext_val;
  logic [2:0] mdma_sup, mdma_sel, s_mdma_sup, s_mdma_sel;
  logic [1:0] pio_adv;
  logic [15:0] cyc_min, cyc_rec, cyl, heads, spt, s_cyc_min, s_cyc_rec;
  logic [31:0] cap, total;
  logic [8:0] s_mult;
  modport src (output mult_max, pio_mode, mult_cnt, stby_std, iordy_sup, iordy_dis,
    min_stby, geom_val, udma_val, ext_val, mult_val, mdma_sup, mdma_sel, pio_adv,
    cyc_min, cyc_rec, cyl, heads, spt, cap, total);
  modport san (input mult_max, pio_mode, mult_cnt, iordy_sup, ext_val, mult_val,
    mdma_sup, mdma_sel, pio_adv, cyc_min, cyc_rec, output s_pio_mode, s_pio_adv,
    s_iordy, s_ext_val, s_mdma_sup, s_mdma_sel, s_cyc_min, s_cyc_rec, s_mult);
  modport mux (input mult_max, stby_std, iordy_dis, min_stby, geom_val, udma_val,
    cyl, heads, spt, cap, total, s_pio_mode, s_pio_adv, s_iordy, s_ext_val,
    s_mdma_sup, s_mdma_sel, s_cyc_min, s_cyc_rec, s_mult);
endinterface : idc_cfg_if

// ### core/idc_pkg.sv
/*
 Constants for the identification capability word block: word indices,
 register map, field positions and timing floors.
 Assumes a 32-bit APB register bus and 16-bit identification words.
*/
package idc_pkg;
  // ****************************************
  // Word indices
  // ****************************************
  typedef logic [6:0] idc_widx_t;
  localparam idc_widx_t W_MULT_MAX = 7'h2f;
  localparam idc_widx_t W_CAP_A = 7'h31;
  localparam idc_widx_t W_CAP_B = 7'h32;
  localparam idc_widx_t W_PIO = 7'h33;
  localparam idc_widx_t W_VALID = 7'h35;
  localparam idc_widx_t W_CYL = 7'h36;
  localparam idc_widx_t W_HEADS = 7'h37;
  localparam idc_widx_t W_SPT = 7'h38;
  localparam idc_widx_t W_CAP_LO = 7'h39;
  localparam idc_widx_t W_CAP_HI = 7'h3a;
  localparam idc_widx_t W_MULT_CUR = 7'h3b;
  localparam idc_widx_t W_TOT_LO = 7'h3c;
  localparam idc_widx_t W_TOT_HI = 7'h3d;
  localparam idc_widx_t W_MDMA = 7'h3f;
  localparam idc_widx_t W_PIO_ADV = 7'h40;
  localparam idc_widx_t W_CYC_MIN = 7'h41;
  localparam idc_widx_t W_CYC_REC = 7'h42;
  // ****************************************
  // Register map
  // ****************************************
  typedef logic [7:0] idc_addr_t;
  localparam idc_addr_t REG_CTRL = 8'h00;
  localparam idc_addr_t REG_DMA = 8'h04;
  localparam idc_addr_t REG_CYC = 8'h08;
  localparam idc_addr_t REG_MULT = 8'h0c;
  localparam idc_addr_t REG_GEOM = 8'h10;
  localparam idc_addr_t REG_SPT = 8'h14;
  localparam idc_addr_t REG_CAP = 8'h18;
  localparam idc_addr_t REG_TOTAL = 8'h1c;
  localparam idc_addr_t REG_IDX = 8'h20;
  localparam idc_addr_t REG_DATA = 8'h24;
  localparam logic [31:0] CTRL_WMASK = 32'h00ff_7fff;
  localparam logic [31:0] DMA_WMASK = 32'h0003_0707;
  localparam logic [31:0] MULT_WMASK = 32'h0000_01ff;
  localparam logic [31:0] SPT_WMASK = 32'h0000_ffff;
  localparam logic [31:0] IDX_WMASK = 32'h0000_007f;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DMA_RST = 32'h0000_0000;
  localparam logic [31:0] CYC_RST = 32'h0000_0000;
  localparam logic [31:0] IDX_RST = 32'h0000_0000;
  // ****************************************
  // Register fields
  // ****************************************
  localparam int CTRL_MULT_LSB = 0;
  localparam int CTRL_STBY_STD = 8;
  localparam int CTRL_IORDY = 9;
  localparam int CTRL_IORDY_DIS = 10;
  localparam int CTRL_MIN_STBY = 11;
  localparam int CTRL_GEOM_VAL = 12;
  localparam int CTRL_UDMA_VAL = 13;
  localparam int CTRL_EXT_VAL = 14;
  localparam int CTRL_PIO_LSB = 16;
  localparam int DMA_SUP_LSB = 0;
  localparam int DMA_SEL_LSB = 8;
  localparam int DMA_ADV_LSB = 16;
  localparam int HALF_LSB = 16;
  localparam int MULT_VAL = 8;
  // ****************************************
  // Word fields and limits
  // ****************************************
  localparam int W49_STBY_STD = 13;
  localparam int W49_IORDY = 11;
  localparam int W49_IORDY_DIS = 10;
  localparam logic [1:0] W49_COMPAT = 2'h3;
  localparam logic [1:0] W50_VALID = 2'h1;
  localparam logic [7:0] PIO_MODE_MAX = 8'h02;
  localparam logic [15:0] MDMA0_MIN_NS = 16'h01e0;
  localparam logic [15:0] MDMA1_MIN_NS = 16'h0096;
  localparam logic [15:0] MDMA2_MIN_NS = 16'h0078;
endpackage : idc_pkg

// ### core/idc_sanitize.sv
/*
 Forces the configured capabilities into a self-consistent set.
 Assumes raw fields straight from software registers.
*/
`timescale 1ns/1ps
module idc_sanitize
  import idc_pkg::*;
(
  // Capability fields
  idc_cfg_if.san c
);
  wire pio3 = |c.pio_adv;
  wire [2:0] sel_m = c.mdma_sel & c.s_mdma_sup;
  wire mdma1 = c.s_mdma_sup[1];
  wire [15:0] floor_ns = c.s_mdma_sup[2] ? MDMA2_MIN_NS : MDMA1_MIN_NS;
  wire [15:0] min_fl = (c.cyc_min < floor_ns) ? floor_ns : c.cyc_min;
  wire [15:0] rec_fl = (c.cyc_rec < min_fl) ? min_fl : c.cyc_rec;
  // Higher modes imply the lower ones
  assign c.s_mdma_sup = {c.mdma_sup[2], |c.mdma_sup[2:1], |c.mdma_sup};
  // Highest supported selection wins, at most one bit
  assign c.s_mdma_sel = sel_m[2] ? 3'h4 : sel_m[1] ? 3'h2 : {2'h0, sel_m[0]};
  assign c.s_iordy = c.iordy_sup | pio3;
  assign c.s_ext_val = c.ext_val | pio3 | mdma1;
  assign c.s_pio_mode = (c.pio_mode > PIO_MODE_MAX) ? PIO_MODE_MAX : c.pio_mode;
  assign c.s_pio_adv = {6'h00, c.pio_adv};
  // Cycle words exist only with mode 1 and up, zero otherwise
  assign c.s_cyc_min = mdma1 ? min_fl : 16'h0000;
  // Slower hosts avoid the flow-control pauses of the device
  assign c.s_cyc_rec = mdma1 ? rec_fl : 16'h0000;
  assign c.s_mult = (c.mult_max == 8'h00) ? 9'h000 : {c.mult_val, c.mult_cnt};
endmodule : idc_sanitize

// ### core/idc_top.sv
/*
 Identification capability words 47 to 66 with an APB register file
 that holds the device's configuration and current settings.
 Assumes ident_idx_i comes from logic on clk_i; APB master on clk_i.
*/
// Notes on behaviour
// - word 47 low byte is multiple limit
// - word 49 bit 13 standard standby table
// - word 49 bit 11 IORDY, forced by PIO3+
// - word 49 bit 10 IORDY can be disabled
// - word 49 bits 9:8 always one
// - word 50 bits 15:14 read 01
// - word 50 bit 0 device minimum standby
// - word 51 high byte PIO mode 0-2
// - word 53 bit 0 words 54-58 valid
// - PIO3+ or MDMA1+ sets word 53 bit 1
// - word 53 bit 2 tracks Ultra DMA validity
// - word 59 bit 8 qualifies current count
// - zero limit forces word 59 bits 8:0 zero
// - at most one MDMA mode selected
// - supported MDMA modes include all lower ones
// - word 64 advanced PIO bits, rest zero
// - word 65 not below fastest mode minimum
// - word 66 never below word 65
// - unsupported fields in 64-70 read zero
// - faster host may see DMA flow pauses
// - reserved bits and words read zero
`timescale 1ns/1ps
module idc_top
  import idc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Identification word port
  input wire idc_widx_t ident_idx_i,
  output logic [15:0] ident_word_o
);
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_r;
  logic [31:0] dma_r;
  logic [31:0] cyc_r;
  logic [31:0] mult_r;
  logic [31:0] geom_r;
  logic [31:0] spt_r;
  logic [31:0] cap_r;
  logic [31:0] total_r;
  logic [31:0] idx_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [15:0] ident_word_r;
  logic [15:0] words [2];
  idc_widx_t sel_idx [2];
  idc_cfg_if cfg ();

  // ****************************************
  // APB decode
  // ****************************************
  wire acc_go = psel_i & penable_i & ~pready_r;
  wire acc_done = psel_i & penable_i & pready_r;
  wire wr_en = acc_done & pwrite_i;
  wire hit_ctrl = paddr_i == REG_CTRL;
  wire hit_dma = paddr_i == REG_DMA;
  wire hit_cyc = paddr_i == REG_CYC;
  wire hit_mult = paddr_i == REG_MULT;
  wire hit_geom = paddr_i == REG_GEOM;
  wire hit_spt = paddr_i == REG_SPT;
  wire hit_cap = paddr_i == REG_CAP;
  wire hit_total = paddr_i == REG_TOTAL;
  wire hit_idx = paddr_i == REG_IDX;
  wire hit_data = paddr_i == REG_DATA;
  wire hit = hit_ctrl | hit_dma | hit_cyc | hit_mult | hit_geom | hit_spt | hit_cap
    | hit_total | hit_idx | hit_data;
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_r :
    hit_dma ? dma_r :
    hit_cyc ? cyc_r :
    hit_mult ? mult_r :
    hit_geom ? geom_r :
    hit_spt ? spt_r :
    hit_cap ? cap_r :
    hit_total ? total_r :
    hit_idx ? idx_r :
    hit_data ? {16'h0000, words[1]} : 32'h0000_0000;

  // ****************************************
  // APB answer, one wait state
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc_go;
      pslverr_r <= acc_go & ~hit;
      prdata_r <= (acc_go & ~pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Configuration writes
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      dma_r <= DMA_RST;
      cyc_r <= CYC_RST;
      mult_r <= 32'h0000_0000;
      geom_r <= 32'h0000_0000;
      spt_r <= 32'h0000_0000;
      cap_r <= 32'h0000_0000;
      total_r <= 32'h0000_0000;
      idx_r <= IDX_RST;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata_i & CTRL_WMASK;
      end
      if (hit_dma) begin
        dma_r <= pwdata_i & DMA_WMASK;
      end
      if (hit_cyc) begin
        cyc_r <= pwdata_i;
      end
      if (hit_mult) begin
        mult_r <= pwdata_i & MULT_WMASK;
      end
      if (hit_geom) begin
        geom_r <= pwdata_i;
      end
      if (hit_spt) begin
        spt_r <= pwdata_i & SPT_WMASK;
      end
      if (hit_cap) begin
        cap_r <= pwdata_i;
      end
      if (hit_total) begin
        total_r <= pwdata_i;
      end
      if (hit_idx) begin
        idx_r <= pwdata_i & IDX_WMASK;
      end
    end
  end

  // ****************************************
  // Fields onto the carrier
  // ****************************************
  assign cfg.mult_max = ctrl_r[CTRL_MULT_LSB +: 8];
  assign cfg.stby_std = ctrl_r[CTRL_STBY_STD];
  assign cfg.iordy_sup = ctrl_r[CTRL_IORDY];
  assign cfg.iordy_dis = ctrl_r[CTRL_IORDY_DIS];
  assign cfg.min_stby = ctrl_r[CTRL_MIN_STBY];
  assign cfg.geom_val = ctrl_r[CTRL_GEOM_VAL];
  assign cfg.udma_val = ctrl_r[CTRL_UDMA_VAL];
  assign cfg.ext_val = ctrl_r[CTRL_EXT_VAL];
  assign cfg.pio_mode = ctrl_r[CTRL_PIO_LSB +: 8];

  // ****************************************
  // DMA, advanced PIO and cycle-time fields
  // ****************************************
  assign cfg.mdma_sup = dma_r[DMA_SUP_LSB +: 3];
  assign cfg.mdma_sel = dma_r[DMA_SEL_LSB +: 3];
  assign cfg.pio_adv = dma_r[DMA_ADV_LSB +: 2];
  assign cfg.cyc_min = cyc_r[0 +: HALF_LSB];
  assign cfg.cyc_rec = cyc_r[HALF_LSB +: 16];

  // ****************************************
  // Current settings and geometry
  // ****************************************
  assign cfg.mult_cnt = mult_r[7:0];
  assign cfg.mult_val = mult_r[MULT_VAL];
  assign cfg.cyl = geom_r[0 +: HALF_LSB];
  assign cfg.heads = geom_r[HALF_LSB +: 16];
  assign cfg.spt = spt_r[15:0];
  assign cfg.cap = cap_r;
  assign cfg.total = total_r;

  idc_sanitize u_san (
    .c(cfg)
  );

  // ****************************************
  // Word assembly for the port and for software
  // ****************************************
  assign sel_idx[0] = ident_idx_i;
  assign sel_idx[1] = idx_r[6:0];
  for (genvar g = 0; g < 2; g++) begin : g_word
    idc_wordmux u_mux (
      .c(cfg),
      .idx_i(sel_idx[g]),
      .word_o(words[g])
    );
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ident_word_r <= 16'h0000;
    end else begin
      ident_word_r <= words[0];
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign ident_word_o = ident_word_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet_pair;
    (ident_idx_i == W_CYC_MIN && !wr_en) ##1 (ident_idx_i == W_CYC_REC && !wr_en);
  endsequence

  sequence s_idx_hold;
    !wr_en ##1 ($stable(ident_idx_i) && !wr_en);
  endsequence

  sequence s_apb_access;
    (psel_i && !penable_i) ##1 (psel_i && penable_i);
  endsequence

  a_w47_limit: assert property (ident_idx_i == W_MULT_MAX |=>
    ident_word_o == {8'h00, $past(ctrl_r[7:0])})
    else $error("word 47 does not show the multiple limit");
  a_w49_compat: assert property (ident_idx_i == W_CAP_A |=>
    ident_word_o[9:8] == W49_COMPAT && ident_word_o[15:14] == 2'h0)
    else $error("word 49 compatibility bits wrong");
  a_w49_iordy: assert property (ident_idx_i == W_CAP_A && |dma_r[17:16] |=>
    ident_word_o[W49_IORDY])
    else $error("IORDY not reported with advanced PIO");
  a_w50_valid: assert property (ident_idx_i == W_CAP_B |=>
    ident_word_o[15:14] == W50_VALID && ident_word_o[13:1] == 13'h0000)
    else $error("word 50 validity pattern wrong");
  a_w51_mode: assert property (ident_idx_i == W_PIO |=>
    ident_word_o[15:8] <= PIO_MODE_MAX && ident_word_o[7:0] == 8'h00)
    else $error("word 51 mode out of range");
  a_w53_ext: assert property (ident_idx_i == W_VALID && (|dma_r[2:1] || |dma_r[17:16])
    |=> ident_word_o[1])
    else $error("word 53 bit 1 missing");
  a_w59_zero: assert property (ident_idx_i == W_MULT_CUR && ctrl_r[7:0] == 8'h00 |=>
    ident_word_o[8:0] == 9'h000)
    else $error("word 59 not zero with zero limit");
  a_w63_onehot: assert property (ident_idx_i == W_MDMA |=>
    $onehot0(ident_word_o[10:8]))
    else $error("more than one DMA mode selected");
  a_w63_chain: assert property (ident_idx_i == W_MDMA |=>
    (!ident_word_o[2] || ident_word_o[1:0] == 2'h3) && (!ident_word_o[1] || ident_word_o[0]))
    else $error("supported DMA modes not cumulative");
  a_w65_floor: assert property (ident_idx_i == W_CYC_MIN && dma_r[2] |=>
    ident_word_o >= MDMA2_MIN_NS)
    else $error("word 65 below mode 2 minimum");
  a_w66_order: assert property (s_quiet_pair |=>
    ident_word_o >= $past(ident_word_o))
    else $error("word 66 below word 65");
  a_apb_answer: assert property (acc_go |=> pready_o ##1 !pready_o)
    else $error("APB answer not one cycle after access");
  a_apb_setup: assert property (s_apb_access |-> !pready_o ##1 pready_o)
    else $error("APB answer not after one wait state");
  a_apb_error: assert property (acc_go && !hit |=> pready_o && pslverr_o)
    else $error("unmapped access without error");

  // ****************************************
  // Checks: words 49 to 53
  // ****************************************
  a_w49_stby: assert property (ident_idx_i == W_CAP_A |=>
    ident_word_o[W49_STBY_STD] == $past(ctrl_r[CTRL_STBY_STD]))
    else $error("word 49 standby table bit wrong");
  a_w49_iordy_sup: assert property (ident_idx_i == W_CAP_A && ctrl_r[CTRL_IORDY] |=>
    ident_word_o[W49_IORDY])
    else $error("IORDY support not reported");
  a_w49_iordy_dis: assert property (ident_idx_i == W_CAP_A |=>
    ident_word_o[W49_IORDY_DIS] == $past(ctrl_r[CTRL_IORDY_DIS]))
    else $error("IORDY disable bit wrong");
  a_w49_retired: assert property (ident_idx_i == W_CAP_A |=>
    ident_word_o[12] == 1'b0 && ident_word_o[7:0] == 8'h00)
    else $error("word 49 unused bits not zero");
  a_w50_stby: assert property (ident_idx_i == W_CAP_B |=>
    ident_word_o[0] == $past(ctrl_r[CTRL_MIN_STBY]))
    else $error("word 50 minimum standby bit wrong");
  a_w51_clamp: assert property (ident_idx_i == W_PIO &&
    ctrl_r[23:16] <= PIO_MODE_MAX |=> ident_word_o[15:8] == $past(ctrl_r[23:16]))
    else $error("word 51 mode not passed through");
  a_w53_geom: assert property (ident_idx_i == W_VALID |=>
    ident_word_o[0] == $past(ctrl_r[CTRL_GEOM_VAL]) && ident_word_o[15:3] == 13'h0000)
    else $error("word 53 geometry validity wrong");
  a_w53_udma: assert property (ident_idx_i == W_VALID |=>
    ident_word_o[2] == $past(ctrl_r[CTRL_UDMA_VAL]))
    else $error("word 53 Ultra DMA validity wrong");

  // ****************************************
  // Checks: words 59 to 66 and the rest
  // ****************************************
  a_w59_count: assert property (ident_idx_i == W_MULT_CUR &&
    ctrl_r[7:0] != 8'h00 |=> ident_word_o == {7'h00, $past(mult_r[8:0])})
    else $error("word 59 current setting wrong");
  a_w63_rsvd: assert property (ident_idx_i == W_MDMA |=>
    ident_word_o[15:11] == 5'h00 && ident_word_o[7:3] == 5'h00)
    else $error("word 63 reserved bits not zero");
  a_w63_sel_sup: assert property (ident_idx_i == W_MDMA |=>
    (ident_word_o[10:8] & ~ident_word_o[2:0]) == 3'h0)
    else $error("selected DMA mode not supported");
  a_w64_field: assert property (ident_idx_i == W_PIO_ADV |=>
    ident_word_o == {14'h0000, $past(dma_r[17:16])})
    else $error("word 64 advanced PIO field wrong");
  a_w65_mode1: assert property (ident_idx_i == W_CYC_MIN &&
    dma_r[1] && !dma_r[2] |=> ident_word_o >= MDMA1_MIN_NS)
    else $error("word 65 below mode 1 minimum");
  a_w65_zero: assert property (ident_idx_i == W_CYC_MIN && dma_r[2:1] == 2'h0 |=>
    ident_word_o == 16'h0000)
    else $error("word 65 not zero without DMA mode 1");
  a_w66_zero: assert property (ident_idx_i == W_CYC_REC && dma_r[2:1] == 2'h0 |=>
    ident_word_o == 16'h0000)
    else $error("word 66 not zero without DMA mode 1");
  a_w66_floor: assert property (ident_idx_i == W_CYC_REC && dma_r[2:1] != 2'h0 |=>
    ident_word_o >= MDMA2_MIN_NS)
    else $error("word 66 below every mode floor");
  a_rsvd_words: assert property (ident_idx_i == 7'h30 || ident_idx_i == 7'h34 ||
    ident_idx_i == 7'h3e |=> ident_word_o == 16'h0000)
    else $error("reserved word not zero");
  a_out_range: assert property (ident_idx_i < W_MULT_MAX || ident_idx_i > W_CYC_REC |=>
    ident_word_o == 16'h0000)
    else $error("word outside the covered range not zero");
  a_word_hold: assert property (s_idx_hold |=> $stable(ident_word_o))
    else $error("word changed with index and state held");
endmodule : idc_top

// ### core/idc_wordmux.sv
/*
 Assembles one 16-bit identification word for a word index.
 Assumes cleaned fields on the carrier; purely combinational.
*/
`timescale 1ns/1ps
module idc_wordmux
  import idc_pkg::*;
(
  // Fields
  idc_cfg_if.mux c,
  // Word select
  input wire idc_widx_t idx_i,
  output logic [15:0] word_o
);
  always_comb begin
    word_o = 16'h0000;
    case (idx_i)
      W_MULT_MAX: word_o[7:0] = c.mult_max;
      W_CAP_A: begin
        word_o[W49_STBY_STD] = c.stby_std;
        word_o[W49_IORDY] = c.s_iordy;
        word_o[W49_IORDY_DIS] = c.iordy_dis;
        word_o[9:8] = W49_COMPAT;
      end
      W_CAP_B: begin
        word_o[15:14] = W50_VALID;
        word_o[0] = c.min_stby;
      end
      W_PIO: word_o[15:8] = c.s_pio_mode;
      W_VALID: word_o[2:0] = {c.udma_val, c.s_ext_val, c.geom_val};
      W_CYL: word_o = c.cyl;
      W_HEADS: word_o = c.heads;
      W_SPT: word_o = c.spt;
      W_CAP_LO: word_o = c.cap[15:0];
      W_CAP_HI: word_o = c.cap[31:16];
      W_MULT_CUR: word_o[8:0] = c.s_mult;
      W_TOT_LO: word_o = c.total[15:0];
      W_TOT_HI: word_o = c.total[31:16];
      W_MDMA: word_o = {5'h00, c.s_mdma_sel, 5'h00, c.s_mdma_sup};
      W_PIO_ADV: word_o[7:0] = c.s_pio_adv;
      W_CYC_MIN: word_o = c.s_cyc_min;
      W_CYC_REC: word_o = c.s_cyc_rec;
      default: word_o = 16'h0000;
    endcase
  end
endmodule : idc_wordmux

// ### tb/idc_host_model.sv
/*
 Host-side reader of the identification words: presents a word index
 and takes the word the device returns.
 Assumes the device answers on the same edge at which it samples the index.
*/
`timescale 1ns/1ps
module idc_host_model
  import idc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Identification word port
  input wire logic [15:0] word_i,
  output idc_widx_t idx_o
);
  initial idx_o = '0;
  // ****************************************
  // Word fetch
  // ****************************************
  // Index held a full cycle so the device samples it settled
  // No pacing assumed of the device; flow pauses are not tolerated
  task automatic get_word(input idc_widx_t i, output logic [15:0] w);
    @(posedge clk_i);
    idx_o <= i;
    @(posedge clk_i);
    #1 w = word_i;
  endtask : get_word
endmodule : idc_host_model

// ### tb/idc_top_tb_top.sv
/*
 Self-checking bench for the identification capability block.
 Assumes an APB slave with one wait state and a registered word port.
*/
`timescale 1ns/1ps
module idc_top_tb_top;
  import idc_pkg::*;
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rerr;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  idc_widx_t ident_idx_i;
  logic [15:0] ident_word_o;
  int failures = 0;
  int cmp_count = 0;
  idc_top i_idc_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ident_idx_i(ident_idx_i),
    .ident_word_o(ident_word_o));
  idc_host_model i_idc_host_model (.clk_i(clk_i), .word_i(ident_word_o),
    .idx_o(ident_idx_i));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input idc_addr_t a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Waits as long as the answer takes; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rd(input idc_addr_t a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic ww(input idc_widx_t i, input logic [15:0] exp);
    logic [15:0] w;
    i_idc_host_model.get_word(i, w);
    chk({16'h0, w}, {16'h0, exp});
  endtask : ww
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int a = 0; a <= 36; a += 4) begin
      rd(a[7:0], 32'h0);
    end
    ww(W_CAP_A, 16'h0300);
    ww(W_CAP_B, 16'h4000);
    ww(W_MULT_CUR, 16'h0000);
    apb(1'b1, REG_CTRL, 32'hffff_ffff);
    rd(REG_CTRL, CTRL_WMASK);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, REG_DATA, 32'h1234_5678);
    rd(REG_DATA, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_caps();
    apb(1'b1, REG_CTRL, 32'h0005_1d10);
    ww(W_MULT_MAX, 16'h0010);
    ww(W_CAP_A, 16'h2700);
    ww(W_CAP_B, 16'h4001);
    ww(W_PIO, 16'h0200);
    ww(W_VALID, 16'h0001);
    apb(1'b1, REG_CTRL, 32'h0001_2200);
    ww(W_CAP_A, 16'h0b00);
    ww(W_VALID, 16'h0004);
    ww(W_PIO, 16'h0100);
    $display("test caps done");
  endtask : t_caps
  task automatic t_mult();
    apb(1'b1, REG_CTRL, 32'h0000_0010);
    apb(1'b1, REG_MULT, 32'h0000_0108);
    ww(W_MULT_CUR, 16'h0108);
    apb(1'b1, REG_CTRL, 32'h0);
    ww(W_MULT_CUR, 16'h0000);
    ww(W_MULT_MAX, 16'h0000);
    $display("test mult done");
  endtask : t_mult
  task automatic t_mdma();
    logic [2:0] v, sc, sl;
    logic [15:0] m;
    apb(1'b1, REG_CYC, 32'h0060_0050);
    for (int s = 0; s < 8; s++) begin
      v = s[2:0];
      sc = v[2] ? 3'h7 : (v[1] ? 3'h3 : {2'h0, v[0]});
      sl = sc[2] ? 3'h4 : (sc[1] ? 3'h2 : sc);
      m = sc[1] ? (sc[2] ? MDMA2_MIN_NS : MDMA1_MIN_NS) : 16'h0;
      apb(1'b1, REG_DMA, {21'h0, 3'h7, 5'h0, v});
      ww(W_MDMA, {5'h0, sl, 5'h0, sc});
      ww(W_VALID, {14'h0, sc[1], 1'b0});
      ww(W_CYC_MIN, m);
      ww(W_CYC_REC, m);
    end
    apb(1'b1, REG_CYC, 32'h0300_0200);
    ww(W_CYC_MIN, 16'h0200);
    ww(W_CYC_REC, 16'h0300);
    apb(1'b1, REG_CYC, 32'h0100_0200);
    ww(W_CYC_REC, 16'h0200);
    $display("test mdma done");
  endtask : t_mdma
  task automatic t_adv();
    apb(1'b1, REG_DMA, 32'h0003_0700);
    ww(W_PIO_ADV, 16'h0003);
    ww(W_CAP_A, 16'h0b00);
    ww(W_VALID, 16'h0002);
    ww(W_CYC_MIN, 16'h0000);
    ww(W_CYC_REC, 16'h0000);
    ww(W_MDMA, 16'h0000);
    $display("test adv done");
  endtask : t_adv
  task automatic t_geom();
    idc_widx_t rsv[5] = '{7'h2e, 7'h30, 7'h34, 7'h3e, 7'h43};
    apb(1'b1, REG_GEOM, 32'h0010_3fff);
    apb(1'b1, REG_SPT, 32'h0000_003f);
    apb(1'b1, REG_CAP, 32'h00fb_fc10);
    apb(1'b1, REG_TOTAL, 32'h0123_4567);
    ww(W_CYL, 16'h3fff);
    ww(W_HEADS, 16'h0010);
    ww(W_SPT, 16'h003f);
    ww(W_CAP_LO, 16'hfc10);
    ww(W_CAP_HI, 16'h00fb);
    ww(W_TOT_LO, 16'h4567);
    ww(W_TOT_HI, 16'h0123);
    for (int k = 0; k < 5; k++) begin
      ww(rsv[k], 16'h0000);
    end
    apb(1'b1, REG_IDX, 32'h0000_0036);
    rd(REG_DATA, 32'h0000_3fff);
    $display("test geom done");
  endtask : t_geom
  // ****************************************
  // Run control
  // ****************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_caps();
    t_mult();
    t_mdma();
    t_adv();
    t_geom();
    tally_and_finish();
  end
  // Run needs about 290 cycles; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
endmodule : idc_top_tb_top
